// *** hdl/lntc_core.sv ***
// Top of the tone control and diagnostic block, with its APB register file.
// Assumes analog monitors present clean synchronous levels on the diag inputs.
`timescale 1ns/1ps
module lntc_core import lntc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tone_key_input,
   input wire logic tone_detector_input,
   input wire logic overtempIn,
   input wire logic overloadIn,
   input wire logic outputLowIn,
   input wire logic powerLowIn,
   input wire logic toneQualityIn,
   input wire logic minLoadIn,
   input wire logic externalSourceIn,
   output logic toneOut,
   output logic filter_bypass_drive,
   output logic detected_data_output,
   output logic [VSEL_W-1:0] voltageSelect,
   output logic lowPowerMode,
   output logic fault_pin_o,
   output logic fault_pin_oe,
   output logic irq
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [VSEL_W-1:0] vsel;
      logic external_tone_select;
      logic tone_enable_bit;
      logic low_power_bit;
      logic [DIAG_W-1:0] diag;
      logic [DIAG_W-1:0] irqStat;
      logic [DIAG_W-1:0] irqMask;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic toneOut;
      logic bypass;
      logic detData;
      logic faultOe;
      logic irq;
   } lntc_core_t;

   lntc_core_t s;
   lntc_core_t next_s;

   lntc_tone_if tone ();

   assign tone.toneEnable = s.tone_enable_bit;
   assign tone.extSelect = s.external_tone_select;
   assign tone.keyIn = tone_key_input;
   assign tone.detSense = tone_detector_input;

   lntc_tone_gen u_gen (
      .ref_clk(ref_clk),
      .rst(rst),
      .tone(tone.gen)
   );

   lntc_tone_detect u_det (
      .ref_clk(ref_clk),
      .rst(rst),
      .det(tone.det)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   logic setup;
   logic access;
   logic wr;
   logic statusRead;
   logic mapped;
   logic [DIAG_W-1:0] cause;
   logic [DIAG_W-1:0] events;

   always_comb begin
      next_s = s;
      setup = psel && !penable;
      access = psel && penable && s.ready;
      wr = access && pwrite;
      mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS1) || (paddr == ADDR_STATUS2) ||
               (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK);
      statusRead = access && !pwrite && ((paddr == ADDR_STATUS1) || (paddr == ADDR_STATUS2));

      // Raw causes in diagnostic bit order
      cause = '0;
      cause[D_OVERTEMP] = overtempIn;
      cause[D_OVERLOAD] = overloadIn;
      cause[D_OUTLOW] = outputLowIn;
      cause[D_PWRLOW] = powerLowIn;
      cause[D_TONEQ] = toneQualityIn;
      cause[D_MINLOAD] = minLoadIn;
      cause[D_EXTSRC] = externalSourceIn;
      cause[D_TONEDET] = tone.tonePresent;

      // Live bits follow their cause; latched ones drop only on a read with the cause gone
      for (int i = 0; i < DIAG_W; i++) begin
         if (LATCH_MASK[i]) begin
            next_s.diag[i] = cause[i] || (s.diag[i] && !statusRead);
         end else begin
            next_s.diag[i] = cause[i];
         end
      end
      events = next_s.diag & ~s.diag;

      // Zero-wait slave: ready in the first access cycle
      next_s.ready = setup;
      next_s.err = setup && !mapped;
      next_s.rdata = '0;
      if (setup && !pwrite) begin
         case (paddr)
            ADDR_CTRL: begin
               next_s.rdata[CTRL_VSEL_LSB +: VSEL_W] = s.vsel;
               next_s.rdata[CTRL_EXT_BIT] = s.external_tone_select;
               next_s.rdata[CTRL_TONE_BIT] = s.tone_enable_bit;
               next_s.rdata[CTRL_LOWPWR_BIT] = s.low_power_bit;
            end
            ADDR_STATUS1: begin
               next_s.rdata[3:0] = s.diag[3:0];
            end
            ADDR_STATUS2: begin
               next_s.rdata[3:0] = s.diag[7:4];
            end
            ADDR_IRQ_STATUS: begin
               next_s.rdata[DIAG_W-1:0] = s.irqStat;
            end
            ADDR_IRQ_MASK: begin
               next_s.rdata[DIAG_W-1:0] = s.irqMask;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end

      if (wr && paddr == ADDR_CTRL) begin
         next_s.vsel = pwdata[CTRL_VSEL_LSB +: VSEL_W];
         next_s.external_tone_select = pwdata[CTRL_EXT_BIT];
         next_s.tone_enable_bit = pwdata[CTRL_TONE_BIT];
         next_s.low_power_bit = pwdata[CTRL_LOWPWR_BIT];
      end
      if (wr && paddr == ADDR_IRQ_MASK) begin
         next_s.irqMask = pwdata[DIAG_W-1:0];
      end
      // Write one to clear, but a new event in the same cycle wins
      if (wr && paddr == ADDR_IRQ_STATUS) begin
         next_s.irqStat = (s.irqStat & ~pwdata[DIAG_W-1:0]) | events;
      end else begin
         next_s.irqStat = s.irqStat | events;
      end
      next_s.irq = |(next_s.irqStat & next_s.irqMask);

      next_s.toneOut = tone.toneWave;
      next_s.bypass = tone.toneActive;
      next_s.detData = tone.tonePresent;
      next_s.faultOe = |(next_s.diag & LATCH_MASK);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign toneOut = s.toneOut;
   assign filter_bypass_drive = s.bypass;
   assign detected_data_output = s.detData;
   assign voltageSelect = s.vsel;
   assign lowPowerMode = s.low_power_bit;
   // Open drain only ever pulls low
   assign fault_pin_o = 1'b0;
   assign fault_pin_oe = s.faultOe;
   assign irq = s.irq;

endmodule

// *** hdl/lntc_pkg.sv ***
// Constants shared by the tone control and diagnostic block.
// Assumes a single 50 MHz clock and APB with 32-bit data.
package lntc_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_MHZ = 50;
   localparam int TONE_HZ = 22000;
   localparam int TONE_HALF_CYC = (CLK_MHZ * 1000000) / (2 * TONE_HZ);
   localparam int EXT_START_NS = 1000;
   localparam int EXT_START_CYC = (EXT_START_NS * CLK_MHZ + 999) / 1000;
   localparam int EXT_STOP_US = 60;
   localparam int EXT_STOP_CYC = EXT_STOP_US * CLK_MHZ;
   localparam int ENV_START_US = 6;
   localparam int ENV_START_CYC = ENV_START_US * CLK_MHZ;
   localparam int ENV_STOP_US = 15;
   localparam int ENV_STOP_CYC = ENV_STOP_US * CLK_MHZ;
   localparam int DET_WINDOW_US = 60;
   localparam int DET_WINDOW_CYC = DET_WINDOW_US * CLK_MHZ;
   localparam int CNT_W = 12;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS1 = 8'h04;
   localparam logic [7:0] ADDR_STATUS2 = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

   // Control fields
   localparam int CTRL_VSEL_LSB = 0;
   localparam int VSEL_W = 4;
   localparam int CTRL_EXT_BIT = 4;
   localparam int CTRL_TONE_BIT = 5;
   localparam int CTRL_LOWPWR_BIT = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;

   // Diagnostic vector: low nibble is status 1, high nibble status 2
   localparam int DIAG_W = 8;
   localparam int D_OVERTEMP = 0;
   localparam int D_OVERLOAD = 1;
   localparam int D_OUTLOW = 2;
   localparam int D_PWRLOW = 3;
   localparam int D_TONEQ = 4;
   localparam int D_MINLOAD = 5;
   localparam int D_EXTSRC = 6;
   localparam int D_TONEDET = 7;
   localparam logic [DIAG_W-1:0] LATCH_MASK = 8'h0b;

   typedef enum logic [1:0] {
      TG_IDLE = 2'b00,
      TG_START = 2'b01,
      TG_ON = 2'b11,
      TG_STOP = 2'b10
   } lntc_tone_state_t;

endpackage

// *** hdl/lntc_tone_if.sv ***
// Signals between the control core, tone generator and tone detector.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface lntc_tone_if;
   logic toneEnable;
   logic extSelect;
   logic keyIn;
   logic toneWave;
   logic toneActive;
   logic detSense;
   logic tonePresent;

   modport ctrl (output toneEnable, output extSelect, output keyIn, output detSense,
                 input toneWave, input toneActive, input tonePresent);
   modport gen (input toneEnable, input extSelect, input keyIn, output toneWave, output toneActive);
   modport det (input detSense, output tonePresent);
endinterface

// *** hdl/lntc_tone_gen.sv ***
// Tone gating and internal 22 kHz generator.
// Assumes the key input is already synchronous to ref_clk.
`timescale 1ns/1ps
module lntc_tone_gen import lntc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   lntc_tone_if.gen tone
);

   typedef struct packed {
      lntc_tone_state_t state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] half;
      logic phase;
      logic keyPrev;
      logic wave;
      logic active;
   } lntc_gen_t;

   lntc_gen_t s;
   lntc_gen_t next_s;
   logic keyEdge;

   always_comb begin
      next_s = s;
      keyEdge = tone.keyIn ^ s.keyPrev;
      next_s.keyPrev = tone.keyIn;
      next_s.cnt = s.cnt + 1'b1;
      if (!tone.toneEnable) begin
         next_s.state = TG_IDLE;
      end else if (tone.extSelect) begin
         // External waveform: key edges keep the tone alive
         case (s.state)
            TG_IDLE: begin
               next_s.cnt = '0;
               if (keyEdge) begin
                  next_s.state = TG_START;
               end
            end
            TG_START: begin
               if (s.cnt == CNT_W'(EXT_START_CYC - 1)) begin
                  next_s.state = TG_ON;
                  next_s.cnt = '0;
               end
            end
            default: begin
               if (keyEdge) begin
                  next_s.cnt = '0;
               end else if (s.cnt == CNT_W'(EXT_STOP_CYC - 1)) begin
                  next_s.state = TG_IDLE;
               end
            end
         endcase
      end else begin
         // Envelope or continuous: key level gates the internal tone
         case (s.state)
            TG_IDLE: begin
               next_s.cnt = '0;
               if (tone.keyIn) begin
                  next_s.state = TG_START;
               end
            end
            TG_START: begin
               if (!tone.keyIn) begin
                  next_s.state = TG_IDLE;
               end else if (s.cnt == CNT_W'(ENV_START_CYC - 1)) begin
                  next_s.state = TG_ON;
               end
            end
            TG_ON: begin
               next_s.cnt = '0;
               if (!tone.keyIn) begin
                  next_s.state = TG_STOP;
               end
            end
            TG_STOP: begin
               if (tone.keyIn) begin
                  next_s.state = TG_ON;
               end else if (s.cnt == CNT_W'(ENV_STOP_CYC - 1)) begin
                  next_s.state = TG_IDLE;
               end
            end
            default: begin
               next_s.state = TG_IDLE;
            end
         endcase
      end
      // Internal oscillator restarts with each burst so the first cycle is whole
      if (s.active && !tone.extSelect) begin
         if (s.half == CNT_W'(TONE_HALF_CYC - 1)) begin
            next_s.half = '0;
            next_s.phase = ~s.phase;
         end else begin
            next_s.half = s.half + 1'b1;
         end
      end else begin
         next_s.half = '0;
         next_s.phase = 1'b1;
      end
      next_s.active = (next_s.state == TG_ON) || (next_s.state == TG_STOP);
      if (!next_s.active) begin
         next_s.wave = 1'b0;
      end else if (tone.extSelect) begin
         next_s.wave = tone.keyIn;
      end else begin
         next_s.wave = s.phase;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '{state: TG_IDLE, cnt: '0, half: '0, phase: 1'b1, keyPrev: 1'b0, wave: 1'b0, active: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign tone.toneWave = s.wave;
   assign tone.toneActive = s.active;

endmodule

// *** hdl/lntc_tone_detect.sv ***
// Tone presence detector on the squared detector input.
// Assumes an external comparator turns the AC-coupled tone into logic.
`timescale 1ns/1ps
module lntc_tone_detect import lntc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   lntc_tone_if.det det
);

   typedef struct packed {
      logic prev;
      logic [CNT_W-1:0] quiet;
      logic present;
   } lntc_det_t;

   lntc_det_t s;
   lntc_det_t next_s;

   always_comb begin
      next_s = s;
      next_s.prev = det.detSense;
      // Present while edges keep arriving within the window
      if (det.detSense != s.prev) begin
         next_s.quiet = '0;
         next_s.present = 1'b1;
      end else if (s.quiet == CNT_W'(DET_WINDOW_CYC - 1)) begin
         next_s.present = 1'b0;
      end else begin
         next_s.quiet = s.quiet + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '{prev: 1'b0, quiet: '0, present: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign det.tonePresent = s.present;

endmodule

// *** bench/lntc_core_properties.sv ***
// Checker bound onto the tone control block, watching its top ports only.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module lntc_core_properties import lntc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tone_detector_input,
   input wire logic overtempIn,
   input wire logic overloadIn,
   input wire logic powerLowIn,
   input wire logic toneOut,
   input wire logic filter_bypass_drive,
   input wire logic detected_data_output,
   input wire logic [VSEL_W-1:0] voltageSelect,
   input wire logic fault_pin_oe
);
   // ************************************************************
   // Helpers
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic rdAcc;
   logic ctrlWr;
   logic latchCause;
   assign rdAcc = psel && penable && pready && !pwrite && (paddr == ADDR_STATUS1 || paddr == ADDR_STATUS2);
   assign ctrlWr = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
   assign latchCause = overloadIn || overtempIn || powerLowIn;
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence apb_access;
      psel && penable;
   endsequence

   // ************************************************************
   // Properties
   // ************************************************************
   chk_ready_answer: assert property (apb_setup ##1 apb_access |-> pready) else $error("no answer");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data leaks");
   chk_vsel_write: assert property (ctrlWr |=> voltageSelect == $past(pwdata[VSEL_W-1:0]))
      else $error("vsel");
   chk_fault_rise: assert property ($rose(latchCause) |-> ##[1:3] fault_pin_oe) else $error("fault late");
   chk_fault_hold: assert property (fault_pin_oe && latchCause |=> fault_pin_oe) else $error("fault lost");
   // The latched bit drops at the status read's access edge, and the pin releases at that same edge
   chk_fault_clear: assert property ($fell(fault_pin_oe) |-> $past(rdAcc))
      else $error("fault cleared without read");
   chk_detect_rise: assert property ($changed(tone_detector_input) |-> ##[1:4] detected_data_output)
      else $error("tone not detected");
   chk_bypass_tone: assert property (toneOut |-> filter_bypass_drive) else $error("bypass low in tone");
   chk_tone_disable: assert property (ctrlWr && !pwdata[CTRL_TONE_BIT] |-> ##[1:4] !toneOut)
      else $error("tone on");
endmodule

bind lntc_core lntc_core_properties chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tone_detector_input(tone_detector_input), .overtempIn(overtempIn), .overloadIn(overloadIn),
   .powerLowIn(powerLowIn), .toneOut(toneOut), .filter_bypass_drive(filter_bypass_drive),
   .detected_data_output(detected_data_output), .voltageSelect(voltageSelect), .fault_pin_oe(fault_pin_oe));

// *** bench/lntc_coax_model.sv ***
// Cable-side model: what the detector comparator sees on the shared coax.
// Assumes the comparator idles low when no tone is on the cable.
`timescale 1ns/1ps
module lntc_coax_model import lntc_pkg::*; (
   input wire logic ref_clk,
   input wire logic toneOut,
   input wire logic replyOn,
   output logic detLine
);
   logic replyWave = 1'b0;
   int halfCnt = 0;
   // Reply burst only while the bench asks, so idle cable stays quiet
   always @(posedge ref_clk) begin
      if (!replyOn) begin
         replyWave <= 1'b0;
         halfCnt <= 0;
      end else if (halfCnt == TONE_HALF_CYC - 1) begin
         replyWave <= ~replyWave;
         halfCnt <= 0;
      end else begin
         halfCnt <= halfCnt + 1;
      end
   end
   // Our own tone is also seen on the shared cable
   assign detLine = toneOut | replyWave;
endmodule

// *** bench/lntc_core_tb.sv ***
// Self-checking bench for the tone control and diagnostic block.
// Assumes the APB timing and tone latencies given with the design.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin badCount++; \
   $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module lntc_core_tb import lntc_pkg::*; ;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic tone_key_input = 1'b0;
   logic replyOn = 1'b0;
   logic [6:0] cause = 7'h00;
   logic [31:0] prdata;
   logic [31:0] rdData;
   logic [VSEL_W-1:0] voltageSelect;
   logic pready, pslverr, tone_detector_input, toneOut, filter_bypass_drive, detected_data_output;
   logic lowPowerMode, fault_pin_oe, irq, rdErr, faultPinO;
   logic [7:0] addrs [5] = '{ADDR_CTRL, ADDR_STATUS1, ADDR_STATUS2, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
   int badCount = 0;
   int compares = 0;
   int cyc;

   lntc_core dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tone_key_input(tone_key_input),
      .tone_detector_input(tone_detector_input), .overtempIn(cause[0]), .overloadIn(cause[1]),
      .outputLowIn(cause[2]), .powerLowIn(cause[3]), .toneQualityIn(cause[4]), .minLoadIn(cause[5]),
      .externalSourceIn(cause[6]), .toneOut(toneOut), .filter_bypass_drive(filter_bypass_drive),
      .detected_data_output(detected_data_output), .voltageSelect(voltageSelect), .lowPowerMode(lowPowerMode),
      .fault_pin_o(faultPinO), .fault_pin_oe(fault_pin_oe), .irq(irq));
   lntc_coax_model coax (.ref_clk(ref_clk), .toneOut(toneOut), .replyOn(replyOn), .detLine(tone_detector_input));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic stop_test;
      $display("Counts: %0d compares, %0d mismatches", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Request held from setup until the edge that samples pready
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Read before the edge's own updates land, so this is what the slave showed at the edge
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         badCount++;
         $display("BAD apb ready expected 1 seen timeout");
         stop_test();
      end
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string nm);
      apb(1'b0, addr, 32'h0);
      `CHK(nm, exp, rdData)
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return toneOut;
         1: return filter_bypass_drive;
         default: return detected_data_output;
      endcase
   endfunction

   task automatic wait_for(input int w, input logic v, input int lim);
      cyc = 0;
      while (pick(w) !== v && cyc < lim) begin
         @(posedge ref_clk);
         #1;
         cyc++;
      end
      if (cyc >= lim) begin
         badCount++;
         $display("BAD wait on output %0d expected %0b seen timeout", w, v);
         stop_test();
      end
   endtask

   task automatic key(input logic v);
      @(posedge ref_clk);
      tone_key_input <= v;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (addrs[i]) rd_chk(addrs[i], 32'h0, "reset value");
      apb(1'b1, 8'h14, 32'hff);
      `CHK("unmapped error", 1'b1, rdErr)
      rd_chk(8'h14, 32'h0, "unmapped read");
      apb(1'b1, ADDR_CTRL, 32'h4a);
      repeat (3) @(negedge ref_clk);
      `CHK("voltage select", 4'ha, voltageSelect)
      `CHK("low power", 1'b1, lowPowerMode)
      rd_chk(ADDR_CTRL, 32'h4a, "control readback");
      $display("Test registers finished");
      @(posedge ref_clk);
      replyOn <= 1'b1;
      wait_for(2, 1'b1, 3 * TONE_HALF_CYC);
      rd_chk(ADDR_STATUS2, 32'h8, "tone present");
      @(posedge ref_clk);
      replyOn <= 1'b0;
      wait_for(2, 1'b0, DET_WINDOW_CYC + 20);
      `CHK("detect window", 1'b1, 1'(cyc >= DET_WINDOW_CYC && cyc <= DET_WINDOW_CYC + 6))
      rd_chk(ADDR_IRQ_STATUS, 32'h80, "event sticky");
      apb(1'b1, ADDR_IRQ_STATUS, 32'h80);
      rd_chk(ADDR_IRQ_STATUS, 32'h0, "event cleared");
      $display("Test detector finished");
      apb(1'b1, ADDR_CTRL, 32'h20);
      key(1'b1);
      wait_for(0, 1'b1, ENV_START_CYC + 20);
      `CHK("envelope start", 1'b1, 1'(cyc >= ENV_START_CYC && cyc <= ENV_START_CYC + 5))
      `CHK("bypass on", 1'b1, filter_bypass_drive)
      wait_for(0, 1'b0, TONE_HALF_CYC + 20);
      `CHK("half period", 1'b1, 1'(cyc >= TONE_HALF_CYC - 1 && cyc <= TONE_HALF_CYC + 1))
      key(1'b0);
      wait_for(1, 1'b0, ENV_STOP_CYC + 20);
      `CHK("envelope stop", 1'b1, 1'(cyc >= ENV_STOP_CYC && cyc <= ENV_STOP_CYC + 5))
      `CHK("tone off", 1'b0, toneOut)
      key(1'b1);
      wait_for(0, 1'b1, ENV_START_CYC + 20);
      apb(1'b1, ADDR_CTRL, 32'h0);
      wait_for(0, 1'b0, 8);
      key(1'b0);
      $display("Test envelope finished");
      apb(1'b1, ADDR_CTRL, 32'h30);
      key(1'b1);
      wait_for(0, 1'b1, EXT_START_CYC + 20);
      `CHK("external start", 1'b1, 1'(cyc >= EXT_START_CYC && cyc <= EXT_START_CYC + 5))
      for (int i = 0; i < 5; i++) begin
         repeat (TONE_HALF_CYC - EXT_START_CYC - 5) @(posedge ref_clk);
         tone_key_input <= ~tone_key_input;
         repeat (EXT_START_CYC + 5) @(negedge ref_clk);
         `CHK("tone follows key", tone_key_input, toneOut)
      end
      wait_for(1, 1'b0, EXT_STOP_CYC + 20);
      cyc = cyc + EXT_START_CYC + 5;
      `CHK("external stop", 1'b1, 1'(cyc >= EXT_STOP_CYC && cyc <= EXT_STOP_CYC + 8))
      apb(1'b1, ADDR_CTRL, 32'h0);
      $display("Test external finished");
      wait_for(2, 1'b0, DET_WINDOW_CYC + 20);
      apb(1'b1, ADDR_IRQ_STATUS, 32'hff);
      apb(1'b1, ADDR_IRQ_MASK, 32'hfe);
      for (int i = 0; i < 7; i++) begin
         logic [7:0] sa;
         sa = i < 4 ? ADDR_STATUS1 : ADDR_STATUS2;
         @(posedge ref_clk);
         cause <= 7'(1 << i);
         repeat (4) @(negedge ref_clk);
         `CHK("irq", 1'(i != 0), irq)
         rd_chk(sa, 32'(1 << (i % 4)), "status set");
         repeat (4) @(negedge ref_clk);
         `CHK("fault pin", LATCH_MASK[i], fault_pin_oe)
         `CHK("fault drive level", 1'b0, faultPinO)
         @(posedge ref_clk);
         cause <= 7'h00;
         repeat (4) @(negedge ref_clk);
         rd_chk(sa, LATCH_MASK[i] ? 32'(1 << (i % 4)) : 32'h0, "status after cause");
         rd_chk(sa, 32'h0, "status after read");
         apb(1'b1, ADDR_IRQ_STATUS, 32'(1 << i));
         repeat (4) @(negedge ref_clk);
         `CHK("fault released", 1'b0, fault_pin_oe)
         `CHK("irq cleared", 1'b0, irq)
      end
      $display("Test diagnostics finished");
      stop_test();
   end
endmodule
